// File: logic/rrt_defs.svh
`ifndef RRT_DEFS_SVH
`define RRT_DEFS_SVH
// ****************************************************************
// Register map
// ****************************************************************
`define RRT_ADDR_W       8
`define RRT_A_CONFIG     8'h00
`define RRT_A_SHORT      8'h04
`define RRT_A_LONG       8'h08
`define RRT_A_RETRY      8'h0C
`define RRT_A_STATUS     8'h10
`define RRT_A_MASK       8'h14
`define RRT_A_STATE      8'h18
// ****************************************************************
// Fields and reset values
// ****************************************************************
`define RRT_MULT_LSB     0
`define RRT_CHEXT_LSB    4
`define RRT_MULT_RST     3'h0
`define RRT_MULT_MAX     3'h5
`define RRT_CHEXT_RST    2'h0
`define RRT_SHORT_RST    16'h0800
`define RRT_LONG_RST     16'h0000
`define RRT_RETRY_RST    4'h2
`define RRT_ST_REQ       0
`define RRT_ST_RETRY     1
`define RRT_ST_CFG       2
`define RRT_ST_W         3
// ****************************************************************
// Control word multiple-use field and bus answers
// ****************************************************************
`define RRT_MU_TOP       39
`define RRT_MU_LSB       24
`define RRT_MU_W         16
`define RRT_CH_BASE_W    8
`define RRT_RESP_OKAY    2'h0
`define RRT_RESP_SLVERR  2'h2
`endif

// File: logic/rrt_pkg.sv
package rrt_pkg;
   typedef enum logic [1:0] {ST_IDLE, ST_SHORT, ST_LONG} rrt_state_t;
   typedef logic [2:0] rrt_mult_t;
   typedef logic [1:0] rrt_chext_t;
endpackage : rrt_pkg

// File: logic/rrt_word_timer.sv
`timescale 1ns/1ps
module rrt_word_timer #(
   parameter int W = 16
) (
   input  wire logic         clk,
   input  wire logic         rst,
   input  wire logic         ce,
   input  wire logic         start,
   input  wire logic         stop,
   input  wire logic         tick,
   input  wire logic [W-1:0] limit,
   output logic              running,
   output logic              expire
);
   logic [W-1:0] count;

   generate
      if (W < 4) begin : g_chk
         $error("rrt_word_timer: width too small");
      end
   endgenerate

   // ****************************************************************
   // Word counter
   // ****************************************************************
   // A restart wins over a stop so that a re-request in the expiry cycle is kept.
   always_ff @(posedge clk) begin
      if (rst) begin
         count   <= '0;
         running <= 1'b0;
         expire  <= 1'b0;
      end else if (ce) begin
         expire <= 1'b0;
         if (start) begin
            count   <= '0;
            running <= 1'b1;
         end else if (stop) begin
            running <= 1'b0;
         end else if (running && tick) begin
            if (count + W'(1) >= limit) begin
               running <= 1'b0;
               expire  <= 1'b1;
            end
            count <= count + W'(1);
         end
      end
   end

   expire_cause_a: assert property (@(posedge clk) disable iff (rst)
      expire |-> $past(running) && $past(tick)) else $error("timer expired while idle");
endmodule : rrt_word_timer

// File: logic/rrt_top.sv
// Functional notes
// - Multiplier codes 0..5 mean x1..x32, codes 6 and 7 are reserved, reset code is 0.
// - The multiplier set here must equal the one used by the remote transmitter.
// - Sequence number and channel extension share the multiple-use control word field.
// - The short timer counts received words from a CRC24 request up to its 16-bit limit.
// - With a non-zero long limit, errors and discontinuities are ignored while short runs.
// - With a zero long limit, errors are ignored but discontinuities accepted while short runs.
// - With a zero long limit, short expiry without a discontinuity re-issues the request.
// - The long timer counts to its limit and re-issues the request if no discontinuity came after short expiry.
// - Re-requests per sequence are counted and the error flag rises at the retry limit.
// - Extension codes 0..3 give 256..2048 channels in word bits 39 down to 32..29.
`timescale 1ns/1ps
`include "rrt_defs.svh"
module rrt_top #(
   parameter int TIMER_W = 16,
   parameter int RETRY_W = 4
) (
   input  wire logic        CLK,
   input  wire logic        RST,
   input  wire logic        CE,
   input  wire logic        RX_WORD_VALID,
   input  wire logic        RX_CRC24_ERR,
   input  wire logic        RX_SEQ_DISCONT,
   input  wire logic        RX_SEQ_EXPECTED,
   input  wire logic        RX_CTRL_VALID,
   input  wire logic [63:0] RX_CTRL_WORD,
   output logic             RETRANS_REQ,
   output logic             RETRY_ERR,
   output logic             IRQ,
   output logic             RX_DEC_VALID,
   output logic [10:0]      RX_CHANNEL,
   output logic [7:0]       RX_SEQ_NUM,
   input  wire logic [7:0]  AWADDR,
   input  wire logic        AWVALID,
   output logic             AWREADY,
   input  wire logic [31:0] WDATA,
   input  wire logic [3:0]  WSTRB,
   input  wire logic        WVALID,
   output logic             WREADY,
   output logic [1:0]       BRESP,
   output logic             BVALID,
   input  wire logic        BREADY,
   input  wire logic [7:0]  ARADDR,
   input  wire logic        ARVALID,
   output logic             ARREADY,
   output logic [31:0]      RDATA,
   output logic [1:0]       RRESP,
   output logic             RVALID,
   input  wire logic        RREADY
);
   rrt_pkg::rrt_state_t  state;
   rrt_pkg::rrt_mult_t   rx_seq_multiplier;
   rrt_pkg::rrt_chext_t  rx_channel_extension;
   logic [TIMER_W-1:0]   short_timer_limit;
   logic [TIMER_W-1:0]   long_timer_limit;
   logic [RETRY_W-1:0]   re_request_limit;
   logic [RETRY_W-1:0]   retry_count;
   logic [`RRT_ST_W-1:0] status;
   logic [`RRT_ST_W-1:0] mask;
   logic [`RRT_ST_W-1:0] st_set;
   logic [`RRT_ST_W-1:0] st_clr;
   logic                 short_run;
   logic                 short_exp;
   logic                 long_run;
   logic                 long_exp;
   logic                 mode_one;
   logic                 issue;
   logic                 first_req;
   logic                 re_req;
   logic                 exhausted;
   logic                 accept_disc;
   logic [`RRT_ADDR_W-1:0] aw_addr;
   logic [31:0]          w_data;
   logic [3:0]           w_strb;
   logic                 aw_full;
   logic                 w_full;
   logic                 do_write;
   logic [31:0]          cur_word;
   logic [31:0]          new_word;

   generate
      if (TIMER_W != 16 || RETRY_W < 2 || RETRY_W > 8) begin : g_chk
         $error("rrt_top: unsupported timer or retry width");
      end
   endgenerate

   // ****************************************************************
   // Helpers
   // ****************************************************************
   function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] d,
                                         input logic [3:0] s);
      logic [31:0] r;
      r = old;
      for (int i = 0; i < 4; i++) begin
         if (s[i]) begin
            r[8*i +: 8] = d[8*i +: 8];
         end
      end
      return r;
   endfunction : merge

   // Returns one when the extension code fits the multiplier code.
   function automatic logic ext_ok(input rrt_pkg::rrt_mult_t m, input rrt_pkg::rrt_chext_t e);
      logic ok;
      ok = 1'b0;
      case (m)
         3'h0, 3'h1, 3'h2: ok = (e == 2'h0);
         3'h3:             ok = (e <= 2'h1);
         3'h4:             ok = (e <= 2'h2);
         3'h5:             ok = 1'b1;
         default:          ok = 1'b0;
      endcase
      return ok;
   endfunction : ext_ok

   // ****************************************************************
   // Request sequencer
   // ****************************************************************
   assign mode_one    = (long_timer_limit != '0);
   assign first_req   = (state == rrt_pkg::ST_IDLE) && RX_CRC24_ERR && !RX_SEQ_EXPECTED;
   assign accept_disc = RX_SEQ_DISCONT && ((state == rrt_pkg::ST_LONG)
                        || (state == rrt_pkg::ST_SHORT && !mode_one));
   assign re_req      = !RX_SEQ_EXPECTED && !accept_disc
                        && ((state == rrt_pkg::ST_SHORT && !mode_one && short_exp)
                        || (state == rrt_pkg::ST_LONG && long_exp));
   assign exhausted   = re_req && (retry_count + RETRY_W'(1) >= re_request_limit);
   assign issue       = first_req || re_req;

   always_ff @(posedge CLK) begin
      if (RST) begin
         state <= rrt_pkg::ST_IDLE;
      end else if (CE) begin
         case (state)
            rrt_pkg::ST_IDLE: begin
               if (first_req) begin
                  state <= rrt_pkg::ST_SHORT;
               end
            end
            rrt_pkg::ST_SHORT: begin
               if (RX_SEQ_EXPECTED || accept_disc || exhausted) begin
                  state <= rrt_pkg::ST_IDLE;
               end else if (mode_one && short_exp) begin
                  state <= rrt_pkg::ST_LONG;
               end
            end
            rrt_pkg::ST_LONG: begin
               if (RX_SEQ_EXPECTED || accept_disc || exhausted) begin
                  state <= rrt_pkg::ST_IDLE;
               end else if (re_req) begin
                  state <= rrt_pkg::ST_SHORT;
               end
            end
            default: state <= rrt_pkg::ST_IDLE;
         endcase
      end
   end

   always_ff @(posedge CLK) begin
      if (RST) begin
         RETRANS_REQ <= 1'b0;
      end else if (CE) begin
         RETRANS_REQ <= issue && !exhausted;
      end
   end

   // The counter is kept across discontinuities so one sequence keeps its budget.
   always_ff @(posedge CLK) begin
      if (RST) begin
         retry_count <= '0;
      end else if (CE) begin
         if (RX_SEQ_EXPECTED && state != rrt_pkg::ST_IDLE) begin
            retry_count <= '0;
         end else if (re_req && !exhausted) begin
            retry_count <= retry_count + RETRY_W'(1);
         end else if (exhausted) begin
            retry_count <= '0;
         end
      end
   end

   rrt_word_timer #(.W(TIMER_W)) u_short (
      .clk     (CLK),
      .rst     (RST),
      .ce      (CE),
      .start   (issue && !exhausted),
      .stop    (RX_SEQ_EXPECTED || accept_disc || exhausted),
      .tick    (RX_WORD_VALID),
      .limit   (short_timer_limit),
      .running (short_run),
      .expire  (short_exp)
   );

   rrt_word_timer #(.W(TIMER_W)) u_long (
      .clk     (CLK),
      .rst     (RST),
      .ce      (CE),
      .start   (issue && !exhausted && mode_one),
      .stop    (RX_SEQ_EXPECTED || accept_disc || exhausted),
      .tick    (RX_WORD_VALID),
      .limit   (long_timer_limit),
      .running (long_run),
      .expire  (long_exp)
   );

   // ****************************************************************
   // Control word field split
   // ****************************************************************
   // The sequence number gets whatever the channel leaves of the shared field.
   always_ff @(posedge CLK) begin
      if (RST) begin
         RX_DEC_VALID <= 1'b0;
         RX_CHANNEL   <= 11'h000;
         RX_SEQ_NUM   <= 8'h00;
      end else if (CE) begin
         RX_DEC_VALID <= RX_CTRL_VALID;
         if (RX_CTRL_VALID) begin
            RX_CHANNEL <= 11'(RX_CTRL_WORD[`RRT_MU_TOP:`RRT_MU_LSB]
                          >> (`RRT_CH_BASE_W - int'(rx_channel_extension)));
            RX_SEQ_NUM <= RX_CTRL_WORD[`RRT_MU_LSB +: 8]
                          & (8'hFF >> rx_channel_extension);
         end
      end
   end

   // ****************************************************************
   // Status, mask and interrupt
   // ****************************************************************
   assign st_set = {!ext_ok(rx_seq_multiplier, rx_channel_extension), exhausted, issue};
   assign st_clr = (do_write && aw_addr == `RRT_A_STATUS && w_strb[0])
                   ? w_data[`RRT_ST_W-1:0] : '0;

   always_ff @(posedge CLK) begin
      if (RST) begin
         status <= '0;
      end else if (CE) begin
         status <= (status & ~st_clr) | st_set;
      end
   end

   always_ff @(posedge CLK) begin
      if (RST) begin
         IRQ <= 1'b0;
      end else if (CE) begin
         IRQ <= |(((status & ~st_clr) | st_set) & mask);
      end
   end

   assign RETRY_ERR = status[`RRT_ST_RETRY];

   // ****************************************************************
   // Register write path
   // ****************************************************************
   assign do_write = aw_full && w_full && !BVALID;

   always_ff @(posedge CLK) begin
      if (RST) begin
         AWREADY <= 1'b1;
         WREADY  <= 1'b1;
         aw_full <= 1'b0;
         w_full  <= 1'b0;
         aw_addr <= '0;
         w_data  <= 32'h0000_0000;
         w_strb  <= 4'h0;
         BVALID  <= 1'b0;
         BRESP   <= `RRT_RESP_OKAY;
      end else if (CE) begin
         if (AWVALID && AWREADY) begin
            AWREADY <= 1'b0;
            aw_full <= 1'b1;
            aw_addr <= AWADDR;
         end
         if (WVALID && WREADY) begin
            WREADY <= 1'b0;
            w_full <= 1'b1;
            w_data <= WDATA;
            w_strb <= WSTRB;
         end
         if (do_write) begin
            aw_full <= 1'b0;
            w_full  <= 1'b0;
            BVALID  <= 1'b1;
            BRESP   <= (aw_addr <= `RRT_A_MASK && aw_addr[1:0] == 2'h0)
                       ? `RRT_RESP_OKAY : `RRT_RESP_SLVERR;
         end
         if (BVALID && BREADY) begin
            BVALID  <= 1'b0;
            AWREADY <= 1'b1;
            WREADY  <= 1'b1;
         end
      end
   end

   // Only the bytes enabled by the strobe replace the current register word.
   always_comb begin
      case (aw_addr)
         `RRT_A_CONFIG: cur_word = 32'(rx_channel_extension) << `RRT_CHEXT_LSB
                                   | 32'(rx_seq_multiplier);
         `RRT_A_SHORT:  cur_word = 32'(short_timer_limit);
         `RRT_A_LONG:   cur_word = 32'(long_timer_limit);
         `RRT_A_RETRY:  cur_word = 32'(re_request_limit);
         `RRT_A_MASK:   cur_word = 32'(mask);
         default:       cur_word = 32'h0000_0000;
      endcase
   end

   assign new_word = merge(cur_word, w_data, w_strb);

   always_ff @(posedge CLK) begin
      if (RST) begin
         rx_seq_multiplier    <= `RRT_MULT_RST;
         rx_channel_extension <= `RRT_CHEXT_RST;
         short_timer_limit    <= `RRT_SHORT_RST;
         long_timer_limit     <= `RRT_LONG_RST;
         re_request_limit     <= `RRT_RETRY_RST;
         mask                 <= '0;
      end else if (CE && do_write) begin
         case (aw_addr)
            `RRT_A_CONFIG: begin
               rx_channel_extension <= new_word[`RRT_CHEXT_LSB +: 2];
               rx_seq_multiplier    <= new_word[`RRT_MULT_LSB +: 3];
            end
            `RRT_A_SHORT: short_timer_limit <= new_word[TIMER_W-1:0];
            `RRT_A_LONG:  long_timer_limit  <= new_word[TIMER_W-1:0];
            `RRT_A_RETRY: re_request_limit  <= new_word[RETRY_W-1:0];
            `RRT_A_MASK:  mask              <= new_word[`RRT_ST_W-1:0];
            default: ;
         endcase
      end
   end

   // ****************************************************************
   // Register read path
   // ****************************************************************
   always_ff @(posedge CLK) begin
      if (RST) begin
         ARREADY <= 1'b1;
         RVALID  <= 1'b0;
         RDATA   <= 32'h0000_0000;
         RRESP   <= `RRT_RESP_OKAY;
      end else if (CE) begin
         if (ARVALID && ARREADY) begin
            ARREADY <= 1'b0;
            RVALID  <= 1'b1;
            RRESP   <= `RRT_RESP_OKAY;
            case (ARADDR)
               `RRT_A_CONFIG: RDATA <= 32'(rx_channel_extension) << `RRT_CHEXT_LSB
                                       | 32'(rx_seq_multiplier);
               `RRT_A_SHORT:  RDATA <= 32'(short_timer_limit);
               `RRT_A_LONG:   RDATA <= 32'(long_timer_limit);
               `RRT_A_RETRY:  RDATA <= 32'(re_request_limit);
               `RRT_A_STATUS: RDATA <= 32'(status);
               `RRT_A_MASK:   RDATA <= 32'(mask);
               `RRT_A_STATE:  RDATA <= {20'h00000, 4'(retry_count), 2'h0, long_run,
                                        short_run, 2'h0, 2'(state)};
               default: begin
                  RDATA <= 32'h0000_0000;
                  RRESP <= `RRT_RESP_SLVERR;
               end
            endcase
         end
         if (RVALID && RREADY) begin
            RVALID  <= 1'b0;
            ARREADY <= 1'b1;
         end
      end
   end

   // ****************************************************************
   // Checks
   // ****************************************************************
   default clocking cb @(posedge CLK); endclocking
   default disable iff (RST);

   first_request_a: assert property (CE && first_req |=> RETRANS_REQ
      && state == rrt_pkg::ST_SHORT) else $error("CRC24 error did not raise a request");
   short_errs_ignored_a: assert property (CE && state == rrt_pkg::ST_SHORT
      && RX_CRC24_ERR && !short_exp |=> !RETRANS_REQ) else $error("error not ignored");
   mode_one_hold_a: assert property (CE && state == rrt_pkg::ST_SHORT && mode_one
      && !RX_SEQ_EXPECTED && !short_exp && RX_SEQ_DISCONT |=> state == rrt_pkg::ST_SHORT)
      else $error("discontinuity taken in mode one");
   mode_two_accept_a: assert property (CE && state == rrt_pkg::ST_SHORT && !mode_one
      && RX_SEQ_DISCONT |=> state == rrt_pkg::ST_IDLE && !RETRANS_REQ)
      else $error("discontinuity not taken in mode two");
   mode_two_rereq_a: assert property (CE && re_req && !exhausted && !mode_one
      |=> RETRANS_REQ ##1 short_run) else $error("short expiry did not re-request");
   long_rereq_a: assert property (CE && state == rrt_pkg::ST_LONG && long_exp
      && !RX_SEQ_EXPECTED && !RX_SEQ_DISCONT |=> RETRANS_REQ || RETRY_ERR)
      else $error("long expiry did not re-request");
   retry_flag_a: assert property (CE && exhausted |=> RETRY_ERR
      && state == rrt_pkg::ST_IDLE) else $error("retry limit did not raise error");
   expected_clear_a: assert property (CE && RX_SEQ_EXPECTED
      && state != rrt_pkg::ST_IDLE |=> retry_count == '0 && state == rrt_pkg::ST_IDLE
      ##1 !short_run && !long_run) else $error("expected sequence did not clear");
   reserved_mult_a: assert property (CE && rx_seq_multiplier > `RRT_MULT_MAX
      |=> status[`RRT_ST_CFG]) else $error("reserved multiplier not flagged");
   channel_split_a: assert property (CE && RX_CTRL_VALID && rx_channel_extension == 2'h0
      |=> RX_CHANNEL == 11'($past(RX_CTRL_WORD[`RRT_MU_TOP:32])))
      else $error("channel split wrong");

   req_cover_c: cover property (first_req ##[1:20] RETRANS_REQ);
   long_cover_c: cover property (state == rrt_pkg::ST_LONG ##1 RETRANS_REQ);
   exhaust_cover_c: cover property ($rose(RETRY_ERR));
   write_cover_c: cover property (BVALID && BREADY);
endmodule : rrt_top

// File: tb/rrt_remote_tx.sv
`timescale 1ns/1ps
// ****************************************************************
// Remote transmitter: streams words and answers requests
// ****************************************************************
module rrt_remote_tx #(
   parameter int LAT = 3
) (
   input  wire logic clk,
   input  wire logic rst,
   input  wire logic answer,
   input  wire logic retrans_req,
   output logic      word_valid,
   output logic      seq_discont
);
   int cnt;
   // A silent partner (answer low) is how the bench exercises the short timer expiry path; the long expiry in t_mode1 runs with answer high.
   always_ff @(posedge clk) begin
      word_valid  <= !rst;
      seq_discont <= 1'b0;
      if (rst) begin
         cnt <= 0;
      end else if (retrans_req && answer) begin
         cnt <= LAT;
      end else if (cnt > 0) begin
         cnt         <= cnt - 1;
         seq_discont <= (cnt == 1);
      end
   end
endmodule : rrt_remote_tx

// File: tb/rx_retrans_request_timers_tb.sv
`timescale 1ns/1ps
`include "rrt_defs.svh"
module rx_retrans_request_timers_tb;
   logic        clk = 1'b0;
   logic        rst = 1'b1;
   logic        crc = 1'b0;
   logic        expd = 1'b0;
   logic        cv = 1'b0;
   logic [63:0] cw = 64'h0;
   logic        ans = 1'b0;
   logic [7:0]  awaddr = 8'h0;
   logic        awvalid = 1'b0;
   logic [31:0] wdata = 32'h0;
   logic        wvalid = 1'b0;
   logic        bready = 1'b0;
   logic [7:0]  araddr = 8'h0;
   logic        arvalid = 1'b0;
   logic        rready = 1'b0;
   logic        wv, disc, req, rerr, irq, dv, awr, wr_r, bv, arr, rv;
   logic [10:0] ch;
   logic [7:0]  sq;
   logic [1:0]  br, rr;
   logic [31:0] rdat;
   int          n_errors = 0;
   int          check_count = 0;
   rrt_top rrt_top_inst (.CLK(clk), .RST(rst), .CE(1'b1), .RX_WORD_VALID(wv),
      .RX_CRC24_ERR(crc), .RX_SEQ_DISCONT(disc), .RX_SEQ_EXPECTED(expd),
      .RX_CTRL_VALID(cv), .RX_CTRL_WORD(cw), .RETRANS_REQ(req), .RETRY_ERR(rerr),
      .IRQ(irq), .RX_DEC_VALID(dv), .RX_CHANNEL(ch), .RX_SEQ_NUM(sq), .AWADDR(awaddr),
      .AWVALID(awvalid), .AWREADY(awr), .WDATA(wdata), .WSTRB(4'hF), .WVALID(wvalid),
      .WREADY(wr_r), .BRESP(br), .BVALID(bv), .BREADY(bready), .ARADDR(araddr),
      .ARVALID(arvalid), .ARREADY(arr), .RDATA(rdat), .RRESP(rr), .RVALID(rv),
      .RREADY(rready));
   rrt_remote_tx rrt_remote_tx_inst (.clk(clk), .rst(rst), .answer(ans), .retrans_req(req),
      .word_valid(wv), .seq_discont(disc));
   initial begin
      forever #25 clk = ~clk;
   end
   // ****************************************************************
   // Shared tasks
   // ****************************************************************
   task automatic stop_test();
      $display("Checks %0d, errors %0d", check_count, n_errors);
      if (n_errors == 0 && check_count > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask : stop_test
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      check_count++;
      if (seen !== exp) begin
         n_errors++;
         $display("Error at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask : check
   // Handshakes are judged on values sampled at the rising edge; ready to answer stays high.
   task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
      awaddr  <= a;
      wdata   <= d;
      awvalid <= 1'b1;
      wvalid  <= 1'b1;
      bready  <= 1'b1;
      for (int i = 0; i < 50; i++) begin
         @(posedge clk);
         if (awvalid && awr) awvalid <= 1'b0;
         if (wvalid && wr_r) wvalid <= 1'b0;
         if (bv) begin
            check(32'(br), 32'(er));
            return;
         end
      end
      n_errors++;
      stop_test();
   endtask : wr
   task automatic rd(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
      araddr  <= a;
      arvalid <= 1'b1;
      rready  <= 1'b1;
      for (int i = 0; i < 50; i++) begin
         @(posedge clk);
         if (arvalid && arr) arvalid <= 1'b0;
         if (rv) begin
            check(rdat, ed);
            check(32'(rr), 32'(er));
            return;
         end
      end
      n_errors++;
      stop_test();
   endtask : rd
   task automatic pulse_crc();
      crc <= 1'b1;
      @(posedge clk);
      crc <= 1'b0;
   endtask : pulse_crc
   // Looks for one request within hi cycles; a found request must not come before lo.
   task automatic req_in(input int lo, input int hi, input logic exp);
      int at;
      at = 0;
      for (int i = 1; i <= hi && at == 0; i++) begin
         @(negedge clk);
         if (req === 1'b1) at = i;
         @(posedge clk);
      end
      check(32'(at != 0), 32'(exp));
      if (exp) check(32'(at >= lo), 32'h1);
   endtask : req_in
   // ****************************************************************
   // Scenarios
   // ****************************************************************
   task automatic t_regs();
      rd(`RRT_A_CONFIG, 32'h0, `RRT_RESP_OKAY);
      rd(`RRT_A_SHORT, 32'h800, `RRT_RESP_OKAY);
      rd(`RRT_A_LONG, 32'h0, `RRT_RESP_OKAY);
      rd(`RRT_A_RETRY, 32'h2, `RRT_RESP_OKAY);
      rd(8'h1C, 32'h0, `RRT_RESP_SLVERR);
      wr(`RRT_A_STATE, 32'h1, `RRT_RESP_SLVERR);
      for (int m = 0; m < 8; m++) begin
         wr(`RRT_A_CONFIG, 32'(m), `RRT_RESP_OKAY);
         rd(`RRT_A_STATUS, 32'(m > 5) << `RRT_ST_CFG, `RRT_RESP_OKAY);
      end
      wr(`RRT_A_CONFIG, 32'h0, `RRT_RESP_OKAY);
      wr(`RRT_A_STATUS, 32'h7, `RRT_RESP_OKAY);
   endtask : t_regs
   task automatic t_decode();
      for (int e = 0; e < 4; e++) begin
         wr(`RRT_A_CONFIG, 32'h5 | (e << `RRT_CHEXT_LSB), `RRT_RESP_OKAY);
         cv <= 1'b1;
         cw <= 64'h0000_00AB_CD00_0000;
         @(posedge clk);
         cv <= 1'b0;
         @(negedge clk);
         check(32'(dv), 32'h1);
         check(32'(ch), 32'hABCD >> (8 - e));
         check(32'(sq), 32'hABCD & ((32'h1 << (8 - e)) - 1));
         @(posedge clk);
      end
      wr(`RRT_A_CONFIG, 32'h0, `RRT_RESP_OKAY);
   endtask : t_decode
   task automatic t_exhaust();
      wr(`RRT_A_SHORT, 32'h9, `RRT_RESP_OKAY);
      wr(`RRT_A_RETRY, 32'h3, `RRT_RESP_OKAY);
      wr(`RRT_A_MASK, 32'h2, `RRT_RESP_OKAY);
      ans <= 1'b0;
      pulse_crc();
      req_in(1, 3, 1'b1);
      req_in(8, 12, 1'b1);
      req_in(8, 12, 1'b1);
      req_in(1, 14, 1'b0);
      check(32'({rerr, irq}), 32'h3);
      rd(`RRT_A_STATUS, 32'h3, `RRT_RESP_OKAY);
      wr(`RRT_A_STATUS, 32'h3, `RRT_RESP_OKAY);
      @(negedge clk);
      check(32'({rerr, irq}), 32'h0);
      @(posedge clk);
   endtask : t_exhaust
   task automatic t_mode2_discont();
      ans <= 1'b1;
      pulse_crc();
      req_in(1, 3, 1'b1);
      req_in(1, 20, 1'b0);
      rd(`RRT_A_STATE, 32'h0, `RRT_RESP_OKAY);
   endtask : t_mode2_discont
   task automatic t_mode1();
      wr(`RRT_A_LONG, 32'd20, `RRT_RESP_OKAY);
      pulse_crc();
      req_in(1, 3, 1'b1);
      pulse_crc();
      req_in(17, 24, 1'b1);
      expd <= 1'b1;
      @(posedge clk);
      expd <= 1'b0;
      rd(`RRT_A_STATE, 32'h0, `RRT_RESP_OKAY);
      req_in(1, 30, 1'b0);
   endtask : t_mode1
   initial begin
      repeat (3) @(posedge clk);
      rst <= 1'b0;
      @(posedge clk);
      t_regs();
      t_decode();
      t_exhaust();
      t_mode2_discont();
      t_mode1();
      stop_test();
   end
endmodule : rx_retrans_request_timers_tb
